// *** shared/hostif_defs.svh ***
// constants for the host interface mode controller: offsets, fields, codes, timing
// assumes one 40 MHz core clock and an apb slave with 32-bit data
`ifndef HOSTIF_DEFS_SVH
`define HOSTIF_DEFS_SVH

`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04

`define CTRL_MODE_LSB 0
`define CTRL_CDSRC_BIT 3
`define CTRL_RATE_LSB 4
`define CTRL_SOFT_BIT 8
`define CTRL_HARD_BIT 9
`define STAT_MSG_BIT 3
`define STAT_RATE_LSB 4
`define STAT_KEY_BIT 8

`define RATE_1200 4'h2
`define RATE_RESET 4'h2
`define CDSRC_RESET 1'b0

`define BYTE_CTRL_C 8'h03
`define BYTE_FEND 8'hc0
`define BYTE_KISS_MID 8'hff
`define BYTE_Q_LOW 8'h71
`define BYTE_Q_UP 8'h51
`define BYTE_CR 8'h0d

`define MSG_STATUS_FIRST 4'h0
`define MSG_STATUS_LAST 4'h2
`define MSG_SIGNON_FIRST 4'h3
`define MSG_SIGNON_LAST 4'hb

`define CLK_PERIOD_NS 25
`define DEFER_NS 10000
`define DEFER_CYC ((`DEFER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOT_CYC 2'h3

`endif

// *** shared/hostif_pkg.sv ***
// types shared by the host interface mode controller
// assumes nothing beyond the constants header
package hostif_pkg;

  typedef enum logic [2:0] {
    MODE_CMD = 3'b000,
    MODE_HOST = 3'b001,
    MODE_KISS = 3'b010,
    MODE_MULTIDROP_EXTENDED_FRAMING_MODE = 3'b011,
    MODE_MODEM = 3'b100
  } mode_type;

endpackage : hostif_pkg

// *** src/message_rom.sv ***
// message table for the status string and the sign-on text
// assumes the reader waits one clock for the registered data
module message_rom (
  input wire logic core_clk,
  input wire logic [3:0] addr,
  output logic [7:0] data_ff
);

  always_ff @(posedge core_clk) begin
    unique case (addr)
      4'h0: data_ff <= 8'h53;
      4'h1: data_ff <= 8'h30;
      4'h2: data_ff <= 8'h30;
      4'h3: data_ff <= 8'h0d;
      4'h4: data_ff <= 8'h0a;
      4'h5: data_ff <= 8'h52;
      4'h6: data_ff <= 8'h45;
      4'h7: data_ff <= 8'h41;
      4'h8: data_ff <= 8'h44;
      4'h9: data_ff <= 8'h59;
      4'ha: data_ff <= 8'h0d;
      4'hb: data_ff <= 8'h0a;
      default: data_ff <= 8'h00;
    endcase
  end

endmodule : message_rom

// *** src/host_interface_mode_control.sv ***
// host interface mode controller: mode selection, exit detectors, message sender,
// kiss byte routing with channel deferral, modem pass-through
// assumes a uart on core_clk supplies and takes whole bytes, and an apb master
`include "hostif_defs.svh"

module host_interface_mode_control
  import hostif_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready_ff,
  output logic [31:0] prdata_ff,
  output logic pslverr_ff,
  input wire logic host_rx_valid,
  input wire logic [7:0] host_rx_data,
  output logic host_rx_ready_ff,
  output logic host_tx_valid_ff,
  output logic [7:0] host_tx_data_ff,
  input wire logic host_tx_ready,
  output logic cmd_rx_valid_ff,
  output logic [7:0] cmd_rx_data_ff,
  input wire logic radio1_demod,
  output logic modem_txd_ff,
  output logic modem_pass_ff,
  input wire logic rx_ind,
  input wire logic ext_cd,
  output logic cd_out_ff,
  output logic [3:0] line_rate_ff,
  input wire logic rf_rx_valid,
  input wire logic [7:0] rf_rx_data,
  output logic rf_rx_ready_ff,
  input wire logic chan_busy,
  output logic radio_tx_valid_ff,
  output logic [7:0] radio_tx_data_ff,
  input wire logic radio_tx_ready,
  input wire logic [2:0] nv_mode_in,
  output logic nv_write_ff,
  output logic [2:0] nv_mode_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // exit sequence matching, shared by all three detectors

  function automatic logic byte_hits(input logic [1:0] det, input logic [1:0] pos,
                                     input logic [7:0] b);
    logic hit;
    hit = 1'b0;
    unique case (det)
      2'd0: hit = (b == `BYTE_CTRL_C);
      2'd1: hit = (pos == 2'd1) ? (b == `BYTE_Q_LOW || b == `BYTE_Q_UP)
                                : (b == `BYTE_FEND);
      default: hit = (pos == 2'd1) ? (b == `BYTE_KISS_MID) : (b == `BYTE_FEND);
    endcase
    return hit;
  endfunction : byte_hits

  function automatic logic [1:0] next_count(input logic [1:0] det, input logic [1:0] cnt,
                                            input logic [7:0] b);
    logic [1:0] res;
    res = 2'd0;
    if (byte_hits(det, cnt, b)) begin
      res = cnt + 2'd1;
    end else if (byte_hits(det, 2'd0, b)) begin
      res = 2'd1;
    end
    return res;
  endfunction : next_count

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] demod_sync_ff;
  logic [1:0] cd_sync_ff;
  logic [1:0] busy_sync_ff;
  logic [5:0] nv_sync_ff;

  always_ff @(posedge core_clk) begin
    demod_sync_ff <= {demod_sync_ff[0], radio1_demod};
    cd_sync_ff <= {cd_sync_ff[0], ext_cd};
    busy_sync_ff <= {busy_sync_ff[0], chan_busy};
    nv_sync_ff <= {nv_sync_ff[2:0], nv_mode_in};
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, write lands at the edge where pready is high

  logic [2:0] mode_sel_ff;
  logic cd_src_ff;
  logic [3:0] rate_set_ff;
  mode_type active_ff;
  logic msg_active_ff;
  logic keyed_ff;
  logic access;
  logic wr_ctrl;
  logic soft_req;
  logic hard_req;

  assign access = psel & penable & pready_ff;
  assign wr_ctrl = access & pwrite & (paddr == `CTRL_OFS);
  assign soft_req = wr_ctrl & pwdata[`CTRL_SOFT_BIT];
  assign hard_req = wr_ctrl & pwdata[`CTRL_HARD_BIT];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & (paddr != `CTRL_OFS)
                    & (paddr != `STAT_OFS);
      prdata_ff <= 32'h0000_0000;
      if (psel & penable & ~pready_ff & ~pwrite) begin
        if (paddr == `CTRL_OFS) begin
          prdata_ff <= {24'h00_0000, rate_set_ff, cd_src_ff, mode_sel_ff};
        end else if (paddr == `STAT_OFS) begin
          prdata_ff <= {23'h00_0000, keyed_ff, line_rate_ff, msg_active_ff, active_ff};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored settings; the mode copy also goes out to non-volatile storage

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cd_src_ff <= `CDSRC_RESET;
      rate_set_ff <= `RATE_RESET;
    end else if (wr_ctrl) begin
      cd_src_ff <= pwdata[`CTRL_CDSRC_BIT];
      rate_set_ff <= pwdata[`CTRL_RATE_LSB +: 4];
    end
  end

  logic [1:0] boot_cnt_ff;
  logic boot_load;

  assign boot_load = (boot_cnt_ff == `BOOT_CYC - 2'd1);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      boot_cnt_ff <= 2'd0;
    end else if (boot_cnt_ff != `BOOT_CYC) begin
      boot_cnt_ff <= boot_cnt_ff + 2'd1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_sel_ff <= MODE_CMD;
      nv_write_ff <= 1'b0;
      nv_mode_ff <= MODE_CMD;
    end else begin
      nv_write_ff <= 1'b0;
      if (boot_load) begin
        mode_sel_ff <= nv_sync_ff[5:3];
      end else if (hard_req) begin
        mode_sel_ff <= MODE_CMD;
        nv_mode_ff <= MODE_CMD;
        nv_write_ff <= 1'b1;
      end else if (wr_ctrl) begin
        mode_sel_ff <= pwdata[`CTRL_MODE_LSB +: 3];
        nv_mode_ff <= pwdata[`CTRL_MODE_LSB +: 3];
        nv_write_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exit detectors: 0 modem, 1 host, 2 kiss and extended kiss

  logic [1:0] match_ff [3];
  logic [2:0] armed;
  logic [2:0] seq_done;
  logic rx_take;

  assign rx_take = host_rx_valid & host_rx_ready_ff;
  assign armed[0] = (active_ff == MODE_MODEM);
  assign armed[1] = (active_ff == MODE_HOST);
  assign armed[2] = (active_ff == MODE_KISS) | (active_ff == MODE_MULTIDROP_EXTENDED_FRAMING_MODE);

  for (genvar d = 0; d < 3; d++) begin : g_det
    logic [1:0] nxt_match;
    assign nxt_match = next_count(2'(d), match_ff[d], host_rx_data);
    assign seq_done[d] = armed[d] & rx_take & (nxt_match == 2'd3);
    always_ff @(posedge core_clk) begin
      if (!rst_n || !armed[d] || seq_done[d]) begin
        match_ff[d] <= 2'd0;
      end else if (rx_take) begin
        match_ff[d] <= nxt_match;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active mode: power-up applies everything, soft reset all but modem

  logic start_status_ff;
  logic start_signon_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      active_ff <= MODE_CMD;
      start_status_ff <= 1'b0;
      start_signon_ff <= 1'b0;
    end else begin
      start_status_ff <= 1'b0;
      start_signon_ff <= 1'b0;
      if (hard_req) begin
        active_ff <= MODE_CMD;
      end else if (|seq_done) begin
        active_ff <= MODE_CMD;
        start_signon_ff <= seq_done[1];
      end else if (boot_load || (soft_req && mode_sel_ff != MODE_MODEM)) begin
        unique case (boot_load ? nv_sync_ff[5:3] : mode_sel_ff)
          MODE_HOST: begin
            active_ff <= MODE_HOST;
            start_status_ff <= 1'b1;
          end
          MODE_KISS: active_ff <= MODE_KISS;
          MODE_MULTIDROP_EXTENDED_FRAMING_MODE: active_ff <= MODE_MULTIDROP_EXTENDED_FRAMING_MODE;
          MODE_MODEM: active_ff <= MODE_MODEM;
          default: active_ff <= MODE_CMD;
        endcase
      end else if (armed[1] && rx_take && host_rx_data == `BYTE_CR
                   && match_ff[1] == 2'd0) begin
        start_status_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial line controls and modem pass-through

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      modem_txd_ff <= 1'b1;
      modem_pass_ff <= 1'b0;
      cd_out_ff <= 1'b0;
      line_rate_ff <= `RATE_RESET;
    end else begin
      modem_pass_ff <= armed[0];
      modem_txd_ff <= demod_sync_ff[1];
      cd_out_ff <= cd_src_ff ? cd_sync_ff[1] : rx_ind;
      line_rate_ff <= armed[0] ? `RATE_1200 : rate_set_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host side transmit: messages first, then radio frames in kiss modes

  logic [3:0] msg_addr_ff;
  logic [3:0] msg_last_ff;
  logic fetch_ff;
  logic [7:0] rom_data;
  logic rf_take;
  logic fetch_go;
  logic nxt_host_valid;

  message_rom u_rom (
    .core_clk(core_clk),
    .addr(msg_addr_ff),
    .data_ff(rom_data)
  );

  assign rf_take = rf_rx_valid & rf_rx_ready_ff;
  assign fetch_go = msg_active_ff & ~fetch_ff & ~host_tx_valid_ff & ~rf_take;
  assign nxt_host_valid = fetch_ff | rf_take | (host_tx_valid_ff & ~host_tx_ready);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      msg_active_ff <= 1'b0;
      msg_addr_ff <= 4'h0;
      msg_last_ff <= 4'h0;
      fetch_ff <= 1'b0;
    end else begin
      fetch_ff <= fetch_go;
      if (start_signon_ff) begin
        msg_active_ff <= 1'b1;
        msg_addr_ff <= `MSG_SIGNON_FIRST;
        msg_last_ff <= `MSG_SIGNON_LAST;
      end else if (start_status_ff && !msg_active_ff) begin
        msg_active_ff <= 1'b1;
        msg_addr_ff <= `MSG_STATUS_FIRST;
        msg_last_ff <= `MSG_STATUS_LAST;
      end else if (fetch_ff) begin
        msg_addr_ff <= msg_addr_ff + 4'h1;
        msg_active_ff <= (msg_addr_ff != msg_last_ff);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      host_tx_valid_ff <= 1'b0;
      host_tx_data_ff <= 8'h00;
      rf_rx_ready_ff <= 1'b0;
    end else begin
      host_tx_valid_ff <= nxt_host_valid;
      if (fetch_ff) begin
        host_tx_data_ff <= rom_data;
      end else if (rf_take) begin
        host_tx_data_ff <= rf_rx_data;
      end
      // ready only when the slot is sure to be free at the next edge
      rf_rx_ready_ff <= armed[2] & ~msg_active_ff & ~start_signon_ff & ~nxt_host_valid
                        & ~rf_take;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host receive: command bytes out, kiss bytes toward the radio

  logic tx_pend_ff;
  logic [7:0] tx_byte_ff;
  logic nxt_tx_pend;
  logic radio_take;

  assign radio_take = radio_tx_valid_ff & radio_tx_ready;
  assign nxt_tx_pend = (tx_pend_ff & ~radio_take) | (rx_take & armed[2]);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_rx_valid_ff <= 1'b0;
      cmd_rx_data_ff <= 8'h00;
      host_rx_ready_ff <= 1'b0;
      tx_pend_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
    end else begin
      cmd_rx_valid_ff <= rx_take & (active_ff == MODE_CMD || armed[1]);
      if (rx_take) begin
        cmd_rx_data_ff <= host_rx_data;
      end
      // stall the uart while a kiss byte waits for the channel
      host_rx_ready_ff <= ~nxt_tx_pend;
      tx_pend_ff <= nxt_tx_pend;
      if (rx_take && armed[2]) begin
        tx_byte_ff <= host_rx_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel access: wait for a quiet channel before keying, hold till fend

  logic [11:0] idle_cnt_ff;
  logic data_seen_ff;
  logic idle_done;

  assign idle_done = (idle_cnt_ff == 12'(`DEFER_CYC));

  always_ff @(posedge core_clk) begin
    if (!rst_n || busy_sync_ff[1]) begin
      idle_cnt_ff <= 12'h000;
    end else if (!idle_done) begin
      idle_cnt_ff <= idle_cnt_ff + 12'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      radio_tx_valid_ff <= 1'b0;
      radio_tx_data_ff <= 8'h00;
      keyed_ff <= 1'b0;
      data_seen_ff <= 1'b0;
    end else begin
      if (radio_take) begin
        radio_tx_valid_ff <= 1'b0;
        if (radio_tx_data_ff == `BYTE_FEND) begin
          keyed_ff <= ~data_seen_ff & keyed_ff;
          data_seen_ff <= 1'b0;
        end else begin
          data_seen_ff <= 1'b1;
        end
      end else if (tx_pend_ff && !radio_tx_valid_ff && (keyed_ff || idle_done)) begin
        radio_tx_valid_ff <= 1'b1;
        radio_tx_data_ff <= tx_byte_ff;
        keyed_ff <= 1'b1;
      end
      if (!armed[2]) begin
        keyed_ff <= 1'b0;
        data_seen_ff <= 1'b0;
      end
    end
  end

endmodule : host_interface_mode_control

// *** sim/hostif_mode_sva.sv ***
// checker for the host interface mode controller, watching top-level ports only
// assumes the single core_clk domain and a synchronous active-low rst_n
module hostif_mode_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready_ff,
  input wire logic host_rx_valid,
  input wire logic [7:0] host_rx_data,
  input wire logic host_rx_ready_ff,
  input wire logic host_tx_valid_ff,
  input wire logic [7:0] host_tx_data_ff,
  input wire logic host_tx_ready,
  input wire logic cmd_rx_valid_ff,
  input wire logic radio1_demod,
  input wire logic modem_txd_ff,
  input wire logic modem_pass_ff,
  input wire logic [3:0] line_rate_ff,
  input wire logic radio_tx_valid_ff,
  input wire logic [7:0] radio_tx_data_ff,
  input wire logic radio_tx_ready,
  input wire logic nv_write_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  apb_one_wait_a: assert property (psel && $rose(penable) |=> pready_ff)
    else $error("apb answer not after one wait state");
  apb_pulse_a: assert property (pready_ff |=> !pready_ff)
    else $error("apb ready longer than one cycle");
  modem_rate_a: assert property (modem_pass_ff |-> line_rate_ff == 4'h2)
    else $error("modem mode not at 1200 rate");
  // two sync stages plus the output register
  modem_copy_a: assert property (
    modem_pass_ff && $past(modem_pass_ff, 4) |-> modem_txd_ff == $past(radio1_demod, 3))
    else $error("modem data not copied through");
  modem_quiet_a: assert property (
    modem_pass_ff |-> !cmd_rx_valid_ff && !host_tx_valid_ff)
    else $error("modem mode added traffic");
  modem_exit_a: assert property (
    (modem_pass_ff && host_rx_valid && host_rx_ready_ff && host_rx_data == 8'h03) [*3]
    |-> ##[1:4] !modem_pass_ff)
    else $error("three ctrl-c did not leave modem mode");
  host_tx_hold_a: assert property (
    host_tx_valid_ff && !host_tx_ready |=> host_tx_valid_ff && $stable(host_tx_data_ff))
    else $error("serial byte dropped before accept");
  radio_hold_a: assert property (
    radio_tx_valid_ff && !radio_tx_ready |=> radio_tx_valid_ff && $stable(radio_tx_data_ff))
    else $error("radio byte dropped before accept");
  nv_pulse_a: assert property (nv_write_ff |=> !nv_write_ff)
    else $error("store write longer than one cycle");
endmodule : hostif_mode_sva

bind host_interface_mode_control hostif_mode_sva u_hostif_mode_sva (.core_clk, .rst_n, .psel,
  .penable, .pready_ff, .host_rx_valid, .host_rx_data, .host_rx_ready_ff, .host_tx_valid_ff,
  .host_tx_data_ff, .host_tx_ready, .cmd_rx_valid_ff, .radio1_demod, .modem_txd_ff,
  .modem_pass_ff, .line_rate_ff, .radio_tx_valid_ff, .radio_tx_data_ff, .radio_tx_ready,
  .nv_write_ff);

// *** sim/host_model.sv ***
// host computer on the serial side: takes transmitted bytes, stalls one cycle in four
// assumes byte-wide valid/ready on core_clk; keeps the first 32 bytes it receives
module host_model (
  input wire logic core_clk,
  input wire logic host_tx_valid_ff,
  input wire logic [7:0] host_tx_data_ff,
  output logic host_tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got [0:31];
  int cnt = 0;
  logic [1:0] ph = 2'h0;
  // periodic stall so held bytes are exercised
  assign host_tx_ready = (ph != 2'h3);
  always @(posedge core_clk) begin
    ph <= ph + 2'h1;
    if (host_tx_valid_ff === 1'b1 && host_tx_ready && cnt < 32) begin
      got[cnt] <= host_tx_data_ff;
      cnt <= cnt + 1;
    end
  end
endmodule : host_model

// *** sim/host_interface_mode_control_tb.sv ***
// testbench for the host interface mode controller: apb master, serial host, radio side
// assumes a tb-held non-volatile store fed from nv_write_ff
`include "hostif_defs.svh"
module host_interface_mode_control_tb
  import hostif_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00, host_rx_data = 8'h00, rf_rx_data = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic host_rx_valid = 0, radio1_demod = 1, rx_ind = 0, ext_cd = 0, rf_rx_valid = 0;
  logic chan_busy = 0, radio_tx_ready = 1;
  logic [2:0] nv_mode_in = 3'h0;
  logic pready_ff, pslverr_ff, host_rx_ready_ff, host_tx_valid_ff, host_tx_ready;
  logic cmd_rx_valid_ff, modem_txd_ff, modem_pass_ff, cd_out_ff, rf_rx_ready_ff;
  logic radio_tx_valid_ff, nv_write_ff;
  logic [31:0] prdata_ff;
  logic [7:0] host_tx_data_ff, cmd_rx_data_ff, radio_tx_data_ff;
  logic [3:0] line_rate_ff;
  logic [2:0] nv_mode_ff;
  int miscompares = 0, samples_checked = 0, n, base;

  host_interface_mode_control u_host_interface_mode_control (.core_clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready_ff, .prdata_ff, .pslverr_ff, .host_rx_valid,
    .host_rx_data, .host_rx_ready_ff, .host_tx_valid_ff, .host_tx_data_ff, .host_tx_ready,
    .cmd_rx_valid_ff, .cmd_rx_data_ff, .radio1_demod, .modem_txd_ff, .modem_pass_ff, .rx_ind,
    .ext_cd, .cd_out_ff, .line_rate_ff, .rf_rx_valid, .rf_rx_data, .rf_rx_ready_ff, .chan_busy,
    .radio_tx_valid_ff, .radio_tx_data_ff, .radio_tx_ready, .nv_mode_in, .nv_write_ff,
    .nv_mode_ff);
  host_model u_host_model (.core_clk, .host_tx_valid_ff, .host_tx_data_ff, .host_tx_ready);

  always #12.5 core_clk = ~core_clk;
  // non-volatile store: survives rst_n, only written on request
  always @(posedge core_clk) if (nv_write_ff === 1'b1) nv_mode_in <= nv_mode_ff;

  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checked %0d miscompared %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task hang;
    miscompares++;
    $display("BAD wait exp done got timeout");
    tally_and_finish;
  endtask : hang
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, seen);
    end
  endtask : chk
  task wait_cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask : wait_cyc
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (pready_ff === 1'b1) break;
    end
    if (n == 20) hang();
    rd = prdata_ff;
    err = pslverr_ff;
    psel <= 0; penable <= 0;
  endtask : apb
  task mode_is(input logic [31:0] m);
    apb(0, `STAT_OFS, 32'h0);
    chk("mode", rd & 32'h7, m);
  endtask : mode_is
  // bytes back to back: valid stays up across takes
  task send(input logic [7:0] b0, b1, b2, b3, input int cnt);
    logic [7:0] b [4];
    b = '{b0, b1, b2, b3};
    @(posedge core_clk);
    host_rx_valid <= 1; host_rx_data <= b[0];
    for (int i = 0; i < cnt; i++) begin
      for (n = 0; n < 2000; n++) begin
        @(posedge core_clk);
        if (host_rx_ready_ff === 1'b1) break;
      end
      if (n == 2000) hang();
      if (i + 1 < cnt) host_rx_data <= b[i + 1];
    end
    host_rx_valid <= 0;
  endtask : send
  task expect_tx(input logic [71:0] seq, input int k);
    for (n = 0; n < 3000 && u_host_model.cnt < base + k; n++) @(posedge core_clk);
    if (n == 3000) hang();
    for (int i = 0; i < k; i++)
      chk("host_tx", 32'(u_host_model.got[base + i]), 32'(seq[8*(k-1-i) +: 8]));
  endtask : expect_tx
  task pwr;
    @(posedge core_clk);
    rst_n <= 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1;
    wait_cyc(6);
  endtask : pwr

  ////////////////////////////////////////////////////////////////////////////////
  task s_regs;
    apb(0, `CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h20);
    apb(1, `STAT_OFS, 32'h7);
    apb(0, `STAT_OFS, 32'h0);
    chk("status", rd, 32'h20);
    apb(0, 8'h08, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    chk("unmapped", rd, 32'h0);
    rx_ind <= 1;
    wait_cyc(5);
    chk("cd", 32'(cd_out_ff), 32'h1);
    rx_ind <= 0;
  endtask : s_regs
  task s_host;
    base = u_host_model.cnt;
    apb(1, `CTRL_OFS, 32'h21);
    mode_is(32'h0);
    apb(1, `CTRL_OFS, 32'h121);
    expect_tx(72'h533030, 3);
    send(8'h41, 8'h0, 8'h0, 8'h0, 1);
    @(posedge core_clk);
    chk("cmd_valid", 32'(cmd_rx_valid_ff), 32'h1);
    chk("cmd_data", 32'(cmd_rx_data_ff), 32'h41);
    base = u_host_model.cnt;
    send(8'h0d, 8'h0, 8'h0, 8'h0, 1);
    expect_tx(72'h533030, 3);
    mode_is(32'h1);
    base = u_host_model.cnt;
    send(8'hc0, 8'hc0, 8'h51, 8'hc0, 4);
    expect_tx(72'h0d0a52454144590d0a, 9);
    mode_is(32'h0);
  endtask : s_host
  task s_kiss;
    apb(1, `CTRL_OFS, 32'h22);
    base = u_host_model.cnt;
    pwr;
    wait_cyc(20);
    chk("kiss_quiet", 32'(u_host_model.cnt - base), 32'h0);
    mode_is(32'h2);
    chan_busy <= 1;
    send(8'h41, 8'h0, 8'h0, 8'h0, 1);
    wait_cyc(450);
    chk("defer", 32'(radio_tx_valid_ff), 32'h0);
    radio_tx_ready <= 0;
    chan_busy <= 0;
    for (n = 0; n < 1000 && radio_tx_valid_ff !== 1'b1; n++) @(posedge core_clk);
    if (n == 1000) hang();
    chk("defer_len", 32'(n > `DEFER_CYC), 32'h1);
    wait_cyc(3);
    chk("radio", 32'(radio_tx_data_ff), 32'h41);
    radio_tx_ready <= 1;
    rf_rx_valid <= 1;
    rf_rx_data <= 8'h5a;
    base = u_host_model.cnt;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (rf_rx_ready_ff === 1'b1) break;
    end
    if (n == 100) hang();
    rf_rx_valid <= 0;
    expect_tx(72'h5a, 1);
    apb(0, `STAT_OFS, 32'h0);
    chk("keyed", 32'(rd[`STAT_KEY_BIT]), 32'h1);
    send(8'hc0, 8'hff, 8'hc0, 8'h0, 3);
    mode_is(32'h0);
  endtask : s_kiss
  task s_multidrop_extended_framing_mode;
    apb(1, `CTRL_OFS, 32'h23);
    pwr;
    mode_is(32'h3);
    apb(1, `CTRL_OFS, 32'h223);
    mode_is(32'h0);
    chk("nv", 32'(nv_mode_in), 32'h0);
  endtask : s_multidrop_extended_framing_mode
  task s_modem;
    apb(1, `CTRL_OFS, 32'h5c);
    pwr;
    // rate and carrier source go back to their reset values on rst_n, so store them again in modem mode
    apb(1, `CTRL_OFS, 32'h5c);
    ext_cd <= 1;
    radio1_demod <= 0;
    wait_cyc(6);
    chk("pass", 32'(modem_pass_ff), 32'h1);
    chk("rate", 32'(line_rate_ff), 32'h2);
    chk("cd_ext", 32'(cd_out_ff), 32'h1);
    chk("txd", 32'(modem_txd_ff), 32'h0);
    radio1_demod <= 1;
    wait_cyc(5);
    chk("txd", 32'(modem_txd_ff), 32'h1);
    send(8'h03, 8'h03, 8'h03, 8'h0, 3);
    wait_cyc(6);
    chk("pass", 32'(modem_pass_ff), 32'h0);
    chk("rate", 32'(line_rate_ff), 32'h5);
  endtask : s_modem

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1;
    wait_cyc(6);
    s_regs;
    s_host;
    s_kiss;
    s_multidrop_extended_framing_mode;
    s_modem;
    tally_and_finish;
  end
endmodule : host_interface_mode_control_tb
